// file: include/pss_regs.vh
// Constants for the power stage serial readout block
`ifndef PSS_REGS_VH
`define PSS_REGS_VH
`define PSS_CLK_PERIOD_NS   50
`define PSS_BIT_DIV         2
`define PSS_ERR_BITS        6
`define PSS_PEAK_BITS       6
`define PSS_START_BIT       1'h1
`define PSS_MODE_W          2
`define PSS_MODE_REG        2'h0
`define PSS_MODE_TRANSIENT  2'h1
`define PSS_MODE_OVUV       2'h2
`define PSS_MODE_RESET      2'h0
`define PSS_SENSE_BITS      10
`endif

// file: core/pss_readout.v
// Serial readout, transient flags and gate command logic of the power stage
`include "pss_regs.vh"

// Notes on behaviour
// R01 - Error word: six bits, MSB first
// R02 - Error equals sensed output minus target code
// R03 - Frame output delimits each word in regulation
// R04 - Peak word: seven bits, leading start one
// R05 - Peak current follows start bit, MSB first
// R06 - Overshoot flag when voltage above upper level
// R07 - Droop flag when voltage below lower level
// R08 - Three modes: regulation, transient, over/under
// R09 - Controller supplies the system clock
// R10 - Controller supplies the interface clock
// R11 - High side on: PWM high, no fault
// R12 - Low side gate follows low-side drive input
// R13 - One serial bit every two clocks
// R14 - Peak output idles low between words
module pss_readout #(
    parameter SENSE_W = `PSS_SENSE_BITS,
    parameter ERR_W   = `PSS_ERR_BITS,
    parameter PEAK_W  = `PSS_PEAK_BITS
) (
    input  wire               CLK_SYS,
    input  wire               RESET_N,
    input  wire               INTF_CLK,
    input  wire [1:0]         CFG_MODE,
    input  wire [SENSE_W-1:0] CFG_TARGET,
    input  wire [SENSE_W-1:0] CFG_UPPER,
    input  wire [SENSE_W-1:0] CFG_LOWER,
    input  wire [SENSE_W-1:0] SENSE_POS,
    input  wire [SENSE_W-1:0] SENSE_NEG,
    input  wire               SAMPLE_VALID,
    output reg                SAMPLE_READY,
    input  wire [PEAK_W-1:0]  PEAK_SAMPLE,
    input  wire               PEAK_VALID,
    output reg                PEAK_READY,
    input  wire               PWM,
    input  wire               FAULT,
    input  wire               LOW_SIDE_DRIVE_IN,
    output reg                ERR_SERIAL,
    output reg                CONV_FRAME,
    output reg                PEAK_CURRENT_SERIAL,
    output reg                OVERSHOOT_FLAG,
    output reg                DROOP_FLAG,
    output reg                HIGH_SIDE_ON,
    output reg                LOW_SIDE_GATE_OUT
);
    localparam S_IDLE  = 2'h1;
    localparam S_SHIFT = 2'h2;
    localparam DW      = SENSE_W + 2;

    // Clamp a signed difference into the signed error word range
    function [ERR_W-1:0] sat_err;
        input signed [DW-1:0] v;
        reg signed [DW-1:0] hi;
        reg signed [DW-1:0] lo;
        begin
            // Built as bit patterns so no 32-bit integer is cut down to the word width
            hi = $signed({{(DW-ERR_W+1){1'b0}}, {(ERR_W-1){1'b1}}});
            lo = $signed({{(DW-ERR_W+1){1'b1}}, {(ERR_W-1){1'b0}}});
            if (v > hi) begin
                sat_err = hi[ERR_W-1:0];
            end else if (v < lo) begin
                sat_err = lo[ERR_W-1:0];
            end else begin
                sat_err = v[ERR_W-1:0];
            end
        end
    endfunction

    // Interface clock and configuration pins are asynchronous: three flops each
    reg [2:0]         iclk_q;
    reg [1:0]         mode_s1_q, mode_s2_q, mode_q;
    reg [SENSE_W-1:0] tgt_s1_q, tgt_s2_q, tgt_q;
    reg [SENSE_W-1:0] up_s1_q, up_s2_q, up_q;
    reg [SENSE_W-1:0] lo_s1_q, lo_s2_q, lo_q;
    reg [2:0]         pwm_s_q, flt_s_q, lsd_s_q;
    wire              iclk_rise = iclk_q[1] & ~iclk_q[2];

    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            iclk_q    <= 3'h0;
            mode_s1_q <= `PSS_MODE_RESET;
            mode_s2_q <= `PSS_MODE_RESET;
            mode_q    <= `PSS_MODE_RESET;
            tgt_s1_q  <= {SENSE_W{1'b0}};
            tgt_s2_q  <= {SENSE_W{1'b0}};
            tgt_q     <= {SENSE_W{1'b0}};
            up_s1_q   <= {SENSE_W{1'b1}};
            up_s2_q   <= {SENSE_W{1'b1}};
            up_q      <= {SENSE_W{1'b1}};
            lo_s1_q   <= {SENSE_W{1'b0}};
            lo_s2_q   <= {SENSE_W{1'b0}};
            lo_q      <= {SENSE_W{1'b0}};
            pwm_s_q   <= 3'h0;
            flt_s_q   <= 3'h7;
            lsd_s_q   <= 3'h0;
        end else begin
            iclk_q    <= {iclk_q[1:0], INTF_CLK};
            mode_s1_q <= CFG_MODE;
            mode_s2_q <= mode_s1_q;
            tgt_s1_q  <= CFG_TARGET;
            tgt_s2_q  <= tgt_s1_q;
            up_s1_q   <= CFG_UPPER;
            up_s2_q   <= up_s1_q;
            lo_s1_q   <= CFG_LOWER;
            lo_s2_q   <= lo_s1_q;
            // Settings only move on an interface clock edge, so a half-changed bus is never used
            if (iclk_rise) begin
                if (mode_s2_q == `PSS_MODE_TRANSIENT || mode_s2_q == `PSS_MODE_OVUV) begin
                    mode_q <= mode_s2_q; // [R08]
                end else begin
                    mode_q <= `PSS_MODE_REG; // [R08]
                end
                tgt_q <= tgt_s2_q;
                up_q  <= up_s2_q;
                lo_q  <= lo_s2_q;
            end
            pwm_s_q <= {pwm_s_q[1:0], PWM};
            flt_s_q <= {flt_s_q[1:0], FAULT};
            lsd_s_q <= {lsd_s_q[1:0], LOW_SIDE_DRIVE_IN};
        end
    end

    // Error computation and transient comparison
    wire signed [DW-1:0] vout = $signed({2'b00, SENSE_POS}) - $signed({2'b00, SENSE_NEG});
    wire signed [DW-1:0] verr = vout - $signed({2'b00, tgt_q}); // [R02]
    wire [ERR_W-1:0]     err_word = sat_err(verr);
    wire                 in_take = SAMPLE_VALID & SAMPLE_READY;

    // Two-entry buffer between sampler and error shifter
    reg [ERR_W-1:0] fifo_mem [0:1];
    reg             wr_ptr_q, rd_ptr_q;
    reg [1:0]       cnt_q;
    reg [1:0]       cnt_d;
    reg [1:0]       err_st_q;
    reg [2:0]       err_bit_q;
    reg [ERR_W-1:0] err_sh_q;
    reg             bit_en_q;
    wire            out_take = (cnt_q != 2'h0) & err_st_q[0] & bit_en_q & (mode_q == `PSS_MODE_REG);

    always @* begin
        cnt_d = cnt_q;
        if (in_take && !out_take) begin
            cnt_d = cnt_q + 2'h1;
        end else if (out_take && !in_take) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always @(posedge CLK_SYS) begin
        if (in_take) begin
            fifo_mem[wr_ptr_q] <= err_word;
        end
    end

    reg [1:0]        pk_st_q;
    reg [2:0]        pk_bit_q;
    reg [PEAK_W:0]   pk_sh_q;

    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ptr_q            <= 1'b0;
            rd_ptr_q            <= 1'b0;
            cnt_q               <= 2'h0;
            SAMPLE_READY        <= 1'b1;
            bit_en_q            <= 1'b0;
            err_st_q            <= S_IDLE;
            err_bit_q           <= 3'h0;
            err_sh_q            <= {ERR_W{1'b0}};
            ERR_SERIAL          <= 1'b0;
            CONV_FRAME          <= 1'b0;
            pk_st_q             <= S_IDLE;
            pk_bit_q            <= 3'h0;
            pk_sh_q             <= {(PEAK_W+1){1'b0}};
            PEAK_READY          <= 1'b0;
            PEAK_CURRENT_SERIAL <= 1'b0;
            OVERSHOOT_FLAG      <= 1'b0;
            DROOP_FLAG          <= 1'b0;
            HIGH_SIDE_ON        <= 1'b0;
            LOW_SIDE_GATE_OUT   <= 1'b0;
        end else begin
            // Halving the clock keeps every bit two cycles wide
            bit_en_q     <= ~bit_en_q; // [R13]
            cnt_q        <= cnt_d;
            SAMPLE_READY <= (cnt_d != 2'h2);
            if (in_take) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            case (err_st_q)
                S_IDLE: begin
                    ERR_SERIAL <= 1'b0;
                    CONV_FRAME <= 1'b0;
                    if (out_take) begin
                        rd_ptr_q   <= ~rd_ptr_q;
                        ERR_SERIAL <= fifo_mem[rd_ptr_q][ERR_W-1]; // [R01]
                        err_sh_q   <= {fifo_mem[rd_ptr_q][ERR_W-2:0], 1'b0};
                        CONV_FRAME <= 1'b1; // [R03]
                        err_bit_q  <= 3'h1;
                        err_st_q   <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (bit_en_q) begin
                        if (err_bit_q == ERR_W[2:0]) begin
                            ERR_SERIAL <= 1'b0;
                            CONV_FRAME <= 1'b0; // [R03]
                            err_st_q   <= S_IDLE;
                        end else begin
                            ERR_SERIAL <= err_sh_q[ERR_W-1]; // [R01]
                            err_sh_q   <= {err_sh_q[ERR_W-2:0], 1'b0};
                            err_bit_q  <= err_bit_q + 3'h1;
                        end
                    end
                end
                default: begin
                    err_st_q <= S_IDLE;
                end
            endcase
            PEAK_READY <= pk_st_q[0] & ~(PEAK_VALID & PEAK_READY & bit_en_q);
            case (pk_st_q)
                S_IDLE: begin
                    PEAK_CURRENT_SERIAL <= 1'b0; // [R14]
                    if (PEAK_VALID && PEAK_READY && bit_en_q) begin
                        pk_sh_q             <= {`PSS_START_BIT, PEAK_SAMPLE}; // [R05]
                        PEAK_CURRENT_SERIAL <= `PSS_START_BIT; // [R04]
                        pk_bit_q            <= 3'h1;
                        pk_st_q             <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (bit_en_q) begin
                        if (pk_bit_q == PEAK_W[2:0] + 3'h1) begin
                            PEAK_CURRENT_SERIAL <= 1'b0; // [R14]
                            pk_st_q             <= S_IDLE;
                        end else begin
                            PEAK_CURRENT_SERIAL <= pk_sh_q[PEAK_W-1]; // [R05]
                            pk_sh_q             <= {pk_sh_q[PEAK_W-1:0], 1'b0};
                            pk_bit_q            <= pk_bit_q + 3'h1;
                        end
                    end
                end
                default: begin
                    pk_st_q <= S_IDLE;
                end
            endcase
            if (SAMPLE_VALID) begin
                OVERSHOOT_FLAG <= (vout > $signed({2'b00, up_q})); // [R06]
                DROOP_FLAG     <= (vout < $signed({2'b00, lo_q})); // [R07]
            end
            HIGH_SIDE_ON      <= pwm_s_q[2] & ~flt_s_q[2]; // [R11]
            LOW_SIDE_GATE_OUT <= lsd_s_q[2]; // [R12]
        end
    end
endmodule // pss_readout

// file: tb/pss_readout_sva.sv
// Port checker for the serial readout block
module pss_readout_sva (
    input logic CLK_SYS,
    input logic RESET_N,
    input logic PWM,
    input logic FAULT,
    input logic LOW_SIDE_DRIVE_IN,
    input logic ERR_SERIAL,
    input logic CONV_FRAME,
    input logic PEAK_CURRENT_SERIAL,
    input logic PEAK_READY,
    input logic OVERSHOOT_FLAG,
    input logic DROOP_FLAG,
    input logic HIGH_SIDE_ON,
    input logic LOW_SIDE_GATE_OUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence peak_word;
        PEAK_CURRENT_SERIAL[*2] ##13 !PEAK_CURRENT_SERIAL;
    endsequence
    sequence err_pace;
        $stable(ERR_SERIAL) ##2 $stable(ERR_SERIAL) ##2 $stable(ERR_SERIAL);
    endsequence
    // Inputs must sit still long enough to pass the three-flop synchroniser
    a_gate_low_follow: assert property ($stable(LOW_SIDE_DRIVE_IN)[*4] |-> LOW_SIDE_GATE_OUT == LOW_SIDE_DRIVE_IN)
        else $error("low side gate off its input");
    a_high_side_cmd: assert property ($stable({PWM, FAULT})[*4] |-> HIGH_SIDE_ON == (PWM && !FAULT))
        else $error("high side switch wrong");
    a_frame_length: assert property ($rose(CONV_FRAME) |-> CONV_FRAME[*6] ##1 CONV_FRAME[*6] ##1 !CONV_FRAME)
        else $error("frame length wrong");
    a_err_bit_pace: assert property ($rose(CONV_FRAME) |=> err_pace)
        else $error("error bit pace wrong");
    a_err_idle_low: assert property (!CONV_FRAME |-> !ERR_SERIAL)
        else $error("error line busy outside frame");
    a_peak_word_len: assert property ($fell(PEAK_READY) |-> peak_word ##1 PEAK_READY)
        else $error("peak word framing wrong");
    a_peak_idle_low: assert property (PEAK_READY |-> !PEAK_CURRENT_SERIAL)
        else $error("peak line not idle low");
    a_flags_apart: assert property (!(OVERSHOOT_FLAG && DROOP_FLAG))
        else $error("both transient flags set");
endmodule // pss_readout_sva
bind pss_readout pss_readout_sva u_sva (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PWM(PWM), .FAULT(FAULT),
    .LOW_SIDE_DRIVE_IN(LOW_SIDE_DRIVE_IN), .ERR_SERIAL(ERR_SERIAL), .CONV_FRAME(CONV_FRAME),
    .PEAK_CURRENT_SERIAL(PEAK_CURRENT_SERIAL), .PEAK_READY(PEAK_READY), .OVERSHOOT_FLAG(OVERSHOOT_FLAG),
    .DROOP_FLAG(DROOP_FLAG), .HIGH_SIDE_ON(HIGH_SIDE_ON), .LOW_SIDE_GATE_OUT(LOW_SIDE_GATE_OUT));

// file: tb/pss_ctrl_model.sv
// Controller model: interface clock source and error word receiver
module pss_ctrl_model (
    input  logic clk_sys,
    input  logic err_serial,
    input  logic conv_frame,
    output logic intf_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0]  words[$];
    logic [11:0] sr_q;
    logic        fr_q = 1'b0;
    initial begin
        intf_clk = 1'b0;
        forever #200 intf_clk = ~intf_clk;
    end
    // Each bit stands two cycles, so only every second sample is kept
    always @(posedge clk_sys) begin
        fr_q <= conv_frame;
        if (conv_frame) sr_q <= {sr_q[10:0], err_serial};
        if (fr_q && !conv_frame) words.push_back({sr_q[11], sr_q[9], sr_q[7], sr_q[5], sr_q[3], sr_q[1]});
    end
endmodule // pss_ctrl_model

// file: tb/tb_top.sv
// Self-checking bench for the serial readout block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       CLK_SYS, RESET_N, INTF_CLK, SAMPLE_VALID, PEAK_VALID, PWM, FAULT, LOW_SIDE_DRIVE_IN;
    logic       SAMPLE_READY, PEAK_READY, ERR_SERIAL, CONV_FRAME, PEAK_CURRENT_SERIAL;
    logic       OVERSHOOT_FLAG, DROOP_FLAG, HIGH_SIDE_ON, LOW_SIDE_GATE_OUT;
    logic [1:0] CFG_MODE;
    logic [9:0] CFG_TARGET, CFG_UPPER, CFG_LOWER, SENSE_POS, SENSE_NEG;
    logic [5:0] PEAK_SAMPLE;
    int         bad_count = 0, tests_run = 0, cycles = 0;
    pss_readout uut (
        .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .INTF_CLK(INTF_CLK), .CFG_MODE(CFG_MODE),
        .CFG_TARGET(CFG_TARGET), .CFG_UPPER(CFG_UPPER), .CFG_LOWER(CFG_LOWER),
        .SENSE_POS(SENSE_POS), .SENSE_NEG(SENSE_NEG), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_READY(SAMPLE_READY), .PEAK_SAMPLE(PEAK_SAMPLE), .PEAK_VALID(PEAK_VALID),
        .PEAK_READY(PEAK_READY), .PWM(PWM), .FAULT(FAULT), .LOW_SIDE_DRIVE_IN(LOW_SIDE_DRIVE_IN),
        .ERR_SERIAL(ERR_SERIAL), .CONV_FRAME(CONV_FRAME), .PEAK_CURRENT_SERIAL(PEAK_CURRENT_SERIAL),
        .OVERSHOOT_FLAG(OVERSHOOT_FLAG), .DROOP_FLAG(DROOP_FLAG), .HIGH_SIDE_ON(HIGH_SIDE_ON),
        .LOW_SIDE_GATE_OUT(LOW_SIDE_GATE_OUT)
    );
    pss_ctrl_model ctl (.clk_sys(CLK_SYS), .err_serial(ERR_SERIAL), .conv_frame(CONV_FRAME), .intf_clk(INTF_CLK));
    initial begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Config is a level loaded on the slow clock, so allow several of its periods
    task automatic cfg(input logic [1:0] m, input logic [9:0] t);
        CFG_MODE <= m;
        CFG_TARGET <= t;
        repeat (30) @(posedge CLK_SYS);
    endtask
    task automatic send(input logic [9:0] p);
        SENSE_POS <= p;
        SAMPLE_VALID <= 1'b1;
        do @(negedge CLK_SYS); while (SAMPLE_READY !== 1'b1);
        @(posedge CLK_SYS);
    endtask
    task automatic test_gate();
        for (int i = 0; i < 8; i++) begin
            {PWM, FAULT, LOW_SIDE_DRIVE_IN} <= 3'(i);
            repeat (5) @(negedge CLK_SYS);
            chk("high side", 10'(PWM & ~FAULT), 10'(HIGH_SIDE_ON));
            chk("low gate", 10'(LOW_SIDE_DRIVE_IN), 10'(LOW_SIDE_GATE_OUT));
            @(posedge CLK_SYS);
        end
        $display("gate test done");
    endtask
    task automatic test_words();
        int d[4] = '{5, -3, 100, -100};
        cfg(2'h0, 10'h078);
        foreach (d[i]) send(10'(d[i] + 136));
        SAMPLE_VALID <= 1'b0;
        repeat (100) if (ctl.words.size() < 4) @(posedge CLK_SYS);
        foreach (d[i]) chk("error word", 10'(d[i] > 31 ? 31 : (d[i] < -32 ? -32 : d[i])) & 10'h03F, 10'(ctl.words[i]));
        ctl.words.delete();
        cfg(2'h1, 10'h000);
        send(10'h014);
        send(10'h01E);
        SAMPLE_VALID <= 1'b0;
        cfg(2'h2, 10'h000);
        chk("ready when full", 10'h000, 10'(SAMPLE_READY));
        chk("words held", 10'h000, 10'(ctl.words.size()));
        // The unused mode code falls back to regulation, so the held words drain here
        cfg(2'h3, 10'h000);
        repeat (20) @(posedge CLK_SYS);
        chk("held count", 10'h002, 10'(ctl.words.size()));
        chk("held word", 10'h004, 10'(ctl.words[0]));
        chk("held word", 10'h00E, 10'(ctl.words[1]));
        $display("word test done");
    endtask
    task automatic test_flags();
        logic [9:0] d[5] = '{10'h0FA, 10'h032, 10'h096, 10'h0C8, 10'h064};
        foreach (d[i]) begin
            send(d[i] + 10'h010);
            SAMPLE_VALID <= 1'b0;
            @(negedge CLK_SYS);
            chk("overshoot", 10'(d[i] > 10'h0C8), 10'(OVERSHOOT_FLAG));
            chk("droop", 10'(d[i] < 10'h064), 10'(DROOP_FLAG));
            @(posedge CLK_SYS);
        end
        $display("flag test done");
    endtask
    task automatic test_peak(input logic [5:0] v);
        logic [5:0] got;
        PEAK_SAMPLE <= v;
        PEAK_VALID <= 1'b1;
        do @(negedge CLK_SYS); while (PEAK_CURRENT_SERIAL !== 1'b1);
        chk("ready at start", 10'h000, 10'(PEAK_READY));
        @(posedge CLK_SYS);
        PEAK_VALID <= 1'b0;
        for (int i = 5; i >= 0; i--) begin
            repeat (2) @(negedge CLK_SYS);
            got[i] = PEAK_CURRENT_SERIAL;
        end
        chk("peak word", 10'(v), 10'(got));
        repeat (2) @(posedge CLK_SYS);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        {RESET_N, SAMPLE_VALID, PEAK_VALID, PWM, FAULT, LOW_SIDE_DRIVE_IN} = '0;
        {CFG_MODE, CFG_TARGET, SENSE_POS, PEAK_SAMPLE} = '0;
        CFG_UPPER = 10'h0C8;
        CFG_LOWER = 10'h064;
        SENSE_NEG = 10'h010;
        repeat (4) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        test_gate();
        test_words();
        test_flags();
        test_peak(6'h2A);
        test_peak(6'h15);
        test_peak(6'h3F);
        $display("peak test done");
        tally_and_finish();
    end
endmodule // tb_top
